// ==== include/txq_pkg.sv ====
package txq_pkg;
	localparam int          WB_DATA_W          = 32;
	localparam int          REG_W              = 8;
	// Register indices; byte address is four times the index
	localparam logic [5:0]  NORMAL_CTRL_IDX    = 6'h1B;
	localparam logic [5:0]  SLOT1_CTRL_IDX     = 6'h1C;
	// Normal queue control fields
	localparam int          N_TRIG_BIT         = 0;
	localparam int          N_SEC_BIT          = 1;
	localparam int          N_ACK_BIT          = 2;
	localparam int          N_IND_BIT          = 3;
	localparam int          N_FP_BIT           = 4;
	// Slot 1 queue control fields
	localparam int          S1_TRIG_BIT        = 0;
	localparam int          S1_SEC_BIT         = 1;
	localparam int          S1_ACK_BIT         = 2;
	localparam int          S1_SLOT_LSB        = 3;
	localparam int          S1_SLOT_W          = 3;
	localparam int          S1_RETRY_LSB       = 6;
	localparam int          S1_RETRY_W         = 2;
	// Reset values
	localparam logic        FLAG_RST           = 1'b0;
	localparam logic [2:0]  SLOT_RST           = 3'h0;
	localparam logic [1:0]  RETRY_RST          = 2'h0;
	localparam logic [31:0] DATA_RST           = 32'h0000_0000;
endpackage

// ==== include/txq_bus_if.sv ====
`timescale 1ns/1ps
interface txq_bus_if;
	logic [7:0] wdata;
	logic       normal_wr;
	logic       slot1_wr;
	logic [7:0] normal_rd;
	logic [7:0] slot1_rd;
	modport port (output wdata, output normal_wr, output slot1_wr, input normal_rd, input slot1_rd);
	modport regs (input wdata, input normal_wr, input slot1_wr, output normal_rd, output slot1_rd);
endinterface

// ==== verilog/txq_wb_port.sv ====
`timescale 1ns/1ps
module txq_wb_port
	import txq_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [ADDR_W-1:0] adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [31:0]       dat_i,
	output logic      [31:0]       dat_o,
	output logic                   ack_o,
	txq_bus_if.port                bus
);
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} port_state_t;

	port_state_t st_r;
	port_state_t st_nxt;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] adr, input logic [5:0] idx);
		reg_hit = (adr[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (adr[1:0] == 2'h0);
	endfunction

	logic req;
	logic wr_now;

	assign req    = cyc_i && stb_i;
	// Writes land on the edge where ack is seen high
	assign wr_now = req && we_i && st_r.ack && sel_i[0];
	assign bus.wdata     = dat_i[7:0];
	assign bus.normal_wr = wr_now && reg_hit(adr_i, NORMAL_CTRL_IDX);
	assign bus.slot1_wr  = wr_now && reg_hit(adr_i, SLOT1_CTRL_IDX);
	assign ack_o = st_r.ack;
	assign dat_o = st_r.dat;

	always_comb begin
		st_nxt     = st_r;
		st_nxt.ack = req && !st_r.ack;
		if (req && !st_r.ack) begin
			// Unmapped addresses are acked and read as zero
			st_nxt.dat = DATA_RST;
			if (reg_hit(adr_i, NORMAL_CTRL_IDX)) begin
				st_nxt.dat = {24'h00_0000, bus.normal_rd};
			end else if (reg_hit(adr_i, SLOT1_CTRL_IDX)) begin
				st_nxt.dat = {24'h00_0000, bus.slot1_rd};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '{ack: 1'b0, dat: DATA_RST};
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// ==== verilog/transmit_fifo_control.sv ====
// Function
// R1 - Upper three bits of normal control are written zero by software, read zero.
// R2 - Read-only bit shows frame-pending flag of the last received acknowledgement.
// R3 - Indirect bit holds normal frame for indirect sending; resets disabled.
// R4 - Ack-request bit makes normal frame expect acknowledgement and retry; resets zero.
// R5 - Security-enable bit applies security to normal frame; resets zero.
// R6 - Writing one to normal trigger starts sending; hardware clears it.
// R7 - Indirect, ack-request and security bits clear at the next normal trigger.
// R8 - Slot 1 security-enable bit applies security to its frame; resets zero.
// R9 - Writing one to slot 1 trigger starts sending; hardware clears it.
// R10 - Slot 1 holds retry 7:6, slot 5:3, ack request 2; retry reads used count.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
module transmit_fifo_control
	import txq_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,

	// Register bus
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,

	// Radio side events
	input  wire logic              ack_received_i,
	input  wire logic              ack_frame_pending_i,
	input  wire logic              slot1_tx_done_i,
	input  wire logic [1:0]        slot1_retries_used_i,

	// Normal queue launch
	output logic                   normal_tx_start_o,
	output logic                   normal_indirect_o,
	output logic                   normal_ack_request_o,
	output logic                   normal_security_enable_o,
	// Slot 1 queue
	output logic                   slot1_tx_start_o,
	output logic                   slot1_ack_request_o,
	output logic                   slot1_security_enable_o,
	output logic      [1:0]        slot1_retry_limit_o,
	output logic      [2:0]        slot1_slot_index_o
);
	typedef struct packed {
		// Stored normal register bits; software reads all but the trigger
		logic       indirect;
		logic       normal_ack_request;
		logic       normal_security_enable;
		logic       normal_tx_trigger;
		logic       frame_pending_status;
		// Options latched at the last normal trigger
		logic       launch_indirect;
		logic       launch_ack_request;
		logic       launch_security;
		// Slot 1 fields
		logic [1:0] slot1_retry_limit;
		logic [1:0] slot1_retry_count;
		logic [2:0] slot1_slot_index;
		logic       slot1_ack_request;
		logic       slot1_security_enable;
		logic       slot1_tx_trigger;
	} ctrl_state_t;

	ctrl_state_t st_r;
	ctrl_state_t st_nxt;

	// Fields of the written byte, normal register
	logic       wr_trig;
	logic       wr_ind;
	logic       wr_ack;
	logic       wr_sec;
	// Fields of the written byte, slot 1 register
	logic [1:0] wr_retry;
	logic [2:0] wr_slot;
	logic       wr_s1_ack;
	logic       wr_s1_sec;
	logic       wr_s1_trig;

	// Everything idles at zero: no frame launched, all options off
	function automatic ctrl_state_t ctrl_reset();
		ctrl_reset = '{
			indirect:               FLAG_RST,
			normal_ack_request:     FLAG_RST,
			normal_security_enable: FLAG_RST,
			normal_tx_trigger:      FLAG_RST,
			frame_pending_status:   FLAG_RST,
			launch_indirect:        FLAG_RST,
			launch_ack_request:     FLAG_RST,
			launch_security:        FLAG_RST,
			slot1_retry_limit:      RETRY_RST,
			slot1_retry_count:      RETRY_RST,
			slot1_slot_index:       SLOT_RST,
			slot1_ack_request:      FLAG_RST,
			slot1_security_enable:  FLAG_RST,
			slot1_tx_trigger:       FLAG_RST
		};
	endfunction

	// Normal register as software reads it; reserved and trigger bits are zero
	function automatic logic [REG_W-1:0] normal_view(input ctrl_state_t s);
		normal_view            = 8'h00; // R1
		normal_view[N_FP_BIT]  = s.frame_pending_status; // R2
		normal_view[N_IND_BIT] = s.indirect;
		normal_view[N_ACK_BIT] = s.normal_ack_request;
		normal_view[N_SEC_BIT] = s.normal_security_enable;
	endfunction

	// Slot 1 register as software reads it; retry field shows retries used
	function automatic logic [REG_W-1:0] slot1_view(input ctrl_state_t s);
		slot1_view                                = 8'h00;
		slot1_view[S1_RETRY_LSB +: S1_RETRY_W]    = s.slot1_retry_count; // R10
		slot1_view[S1_SLOT_LSB +: S1_SLOT_W]      = s.slot1_slot_index;
		slot1_view[S1_ACK_BIT]                    = s.slot1_ack_request;
		slot1_view[S1_SEC_BIT]                    = s.slot1_security_enable;
	endfunction

	assign wr_trig    = bus.wdata[N_TRIG_BIT];
	assign wr_ind     = bus.wdata[N_IND_BIT];
	assign wr_ack     = bus.wdata[N_ACK_BIT];
	assign wr_sec     = bus.wdata[N_SEC_BIT];
	assign wr_retry   = bus.wdata[S1_RETRY_LSB +: S1_RETRY_W];
	assign wr_slot    = bus.wdata[S1_SLOT_LSB +: S1_SLOT_W];
	assign wr_s1_ack  = bus.wdata[S1_ACK_BIT];
	assign wr_s1_sec  = bus.wdata[S1_SEC_BIT];
	assign wr_s1_trig = bus.wdata[S1_TRIG_BIT];

	txq_bus_if bus ();

	// Wishbone front end; writes land at the edge where ack is seen
	txq_wb_port #(
		.ADDR_W (ADDR_W)
	) u_port (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cyc_i (wb_cyc_i),
		.stb_i (wb_stb_i),
		.we_i  (wb_we_i),
		.adr_i (wb_adr_i),
		.sel_i (wb_sel_i),
		.dat_i (wb_dat_i),
		.dat_o (wb_dat_o),
		.ack_o (wb_ack_o),
		.bus   (bus.port)
	);

	// Trigger bits read as zero; reserved bits read as zero
	always_comb begin
		bus.normal_rd = normal_view(st_r); // R1 R2
		bus.slot1_rd  = slot1_view(st_r); // R10
	end

	always_comb begin
		st_nxt = st_r;
		// Trigger pulses last one cycle
		st_nxt.normal_tx_trigger = 1'b0; // R6
		st_nxt.slot1_tx_trigger  = 1'b0; // R9

		// Status taken from the radio side; software cannot write these
		if (ack_received_i) begin
			st_nxt.frame_pending_status = ack_frame_pending_i; // R2
		end
		if (slot1_tx_done_i) begin
			st_nxt.slot1_retry_count = slot1_retries_used_i; // R10
		end

		// Normal queue register write
		if (bus.normal_wr) begin
			if (wr_trig) begin
				// Options of this write go with the frame, stored bits clear
				st_nxt.normal_tx_trigger      = 1'b1; // R6
				st_nxt.launch_indirect        = wr_ind; // R3
				st_nxt.launch_ack_request     = wr_ack; // R4
				st_nxt.launch_security        = wr_sec; // R5
				st_nxt.indirect               = 1'b0; // R7
				st_nxt.normal_ack_request     = 1'b0; // R7
				st_nxt.normal_security_enable = 1'b0; // R7
			end else begin
				// An untriggered write only stores the options
				st_nxt.indirect               = wr_ind; // R3
				st_nxt.normal_ack_request     = wr_ack; // R4
				st_nxt.normal_security_enable = wr_sec; // R5
			end
		end

		// Slot 1 queue register write; the trigger lives for one cycle
		if (bus.slot1_wr) begin
			st_nxt.slot1_retry_limit     = wr_retry; // R10
			st_nxt.slot1_slot_index      = wr_slot; // R10
			st_nxt.slot1_ack_request     = wr_s1_ack; // R10
			st_nxt.slot1_security_enable = wr_s1_sec; // R8
			st_nxt.slot1_tx_trigger      = wr_s1_trig; // R9
		end
	end

	// All control state lives in one register with a synchronous reset; the port keeps ack and read data in its own
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= ctrl_reset(); // R3 R4 R5 R8
		end else begin
			st_r <= st_nxt;
		end
	end

	// Normal queue launch outputs
	assign normal_tx_start_o        = st_r.normal_tx_trigger; // R6
	assign normal_indirect_o        = st_r.launch_indirect; // R3
	assign normal_ack_request_o     = st_r.launch_ack_request; // R4
	assign normal_security_enable_o = st_r.launch_security; // R5

	// Slot 1 queue outputs
	assign slot1_tx_start_o         = st_r.slot1_tx_trigger; // R9
	assign slot1_ack_request_o      = st_r.slot1_ack_request;
	assign slot1_security_enable_o  = st_r.slot1_security_enable; // R8
	assign slot1_retry_limit_o      = st_r.slot1_retry_limit;
	assign slot1_slot_index_o       = st_r.slot1_slot_index;
endmodule

// ==== bench/txq_chk.sv ====
`timescale 1ns/1ps
module txq_chk
	import txq_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0]        wb_sel_i,
	input wire logic [31:0]       wb_dat_i,
	input wire logic              wb_ack_o,
	input wire logic              normal_tx_start_o,
	input wire logic              normal_indirect_o,
	input wire logic              normal_ack_request_o,
	input wire logic              normal_security_enable_o,
	input wire logic              slot1_tx_start_o,
	input wire logic              slot1_ack_request_o,
	input wire logic              slot1_security_enable_o,
	input wire logic [1:0]        slot1_retry_limit_o,
	input wire logic [2:0]        slot1_slot_index_o
);
	logic nw;
	logic sw;
	// Accepted writes, seen at the ack edge where they take effect
	assign nw = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_W'({NORMAL_CTRL_IDX, 2'b00});
	assign sw = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_W'({SLOT1_CTRL_IDX, 2'b00});
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	a_norm_start: assert property (nw && wb_dat_i[0] |=> normal_tx_start_o) else $error("no normal start");
	a_norm_start_cause: assert property (normal_tx_start_o |-> $past(nw && wb_dat_i[0])) else $error("stray start");
	a_norm_opts: assert property (nw && wb_dat_i[0] |=>
		{normal_indirect_o, normal_ack_request_o, normal_security_enable_o} == $past(wb_dat_i[3:1]))
		else $error("normal options wrong");
	a_norm_opts_hold: assert property (!(nw && wb_dat_i[0]) |=>
		$stable({normal_indirect_o, normal_ack_request_o, normal_security_enable_o}))
		else $error("normal options moved");
	a_slot_start: assert property (sw && wb_dat_i[0] |=> slot1_tx_start_o) else $error("no slot1 start");
	a_slot_fields: assert property (sw |=> {slot1_retry_limit_o, slot1_slot_index_o, slot1_ack_request_o,
		slot1_security_enable_o} == $past(wb_dat_i[7:1])) else $error("slot1 fields wrong");
endmodule
bind transmit_fifo_control txq_chk #(.ADDR_W(ADDR_W)) txq_chk_inst (.*);

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	import txq_pkg::*;
	localparam logic [7:0] NA = {NORMAL_CTRL_IDX, 2'b00};
	localparam logic [7:0] SA = {SLOT1_CTRL_IDX, 2'b00};
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, arx = 1'b0, fp = 1'b0, dn = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, r;
	logic [1:0] used = 2'h0, lim;
	logic [2:0] idx;
	logic ack, ntx, nind, nack, nsec, stx, sack, ssec;
	logic [32:0] q[$];
	logic [32:0] e;
	int err_total = 0, n_tests = 0, cycles = 0;
	integer seed = 71954;
	always #2.5 clk_i = ~clk_i;
	transmit_fifo_control transmit_fifo_control_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.ack_received_i(arx), .ack_frame_pending_i(fp), .slot1_tx_done_i(dn), .slot1_retries_used_i(used),
		.normal_tx_start_o(ntx), .normal_indirect_o(nind), .normal_ack_request_o(nack),
		.normal_security_enable_o(nsec), .slot1_tx_start_o(stx), .slot1_ack_request_o(sack),
		.slot1_security_enable_o(ssec), .slot1_retry_limit_o(lim), .slot1_slot_index_o(idx));
	task chk(input string n, input logic [31:0] x, input logic [31:0] s);
		n_tests++;
		if (s !== x) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, x, s);
		end
	endtask
	task finish_test;
		if (err_total == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Expectation bit 32 set means the ack carries read data to compare
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
		q.push_back(x);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task hw(input logic a, input logic f, input logic d, input logic [1:0] u);
		arx <= a;
		fp <= f;
		dn <= d;
		used <= u;
		@(posedge clk_i);
		arx <= 1'b0;
		dn <= 1'b0;
		@(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		if (ack === 1'b1) begin
			e = q.pop_front();
			if (e[32]) chk("read data", e[31:0], rdat);
		end
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			finish_test();
		end
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("reset outputs", 32'h0, 32'({ntx, nind, nack, nsec, stx, sack, ssec, lim, idx}));
		bus(1'b0, NA, 32'h0, {1'b1, 32'h0});
		bus(1'b0, SA, 32'h0, {1'b1, 32'h0});
		bus(1'b1, NA, 32'h0E, 33'h0);
		bus(1'b0, NA, 32'h0, {1'b1, 32'h0E});
		bus(1'b1, NA, 32'h0B, 33'h0);
		chk("normal options", 32'h5, 32'({nind, nack, nsec}));
		bus(1'b0, NA, 32'h0, {1'b1, 32'h0});
		bus(1'b1, NA, 32'h05, 33'h0);
		chk("normal options", 32'h2, 32'({nind, nack, nsec}));
		hw(1'b1, 1'b1, 1'b0, 2'h0);
		bus(1'b0, NA, 32'h0, {1'b1, 32'h10});
		hw(1'b1, 1'b0, 1'b0, 2'h0);
		bus(1'b0, NA, 32'h0, {1'b1, 32'h0});
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			bus(1'b1, SA, {24'h0, r[7:1], 1'b1}, 33'h0);
			chk("slot1 outputs", 32'(r[7:1]), 32'({lim, idx, sack, ssec}));
			hw(1'b0, 1'b0, 1'b1, r[9:8]);
			bus(1'b0, SA, 32'h0, {1'b1, 24'h0, r[9:8], r[5:1], 1'b0});
		end
		bus(1'b1, 8'h74, 32'hFF, 33'h0);
		bus(1'b0, 8'h74, 32'h0, {1'b1, 32'h0});
		finish_test();
	end
endmodule
